// ### src/sqp_pkg.sv
/*
  Package for the receive queue pointer and configuration register bank:
  register indexes, field layouts, reset values, timing constants, carriers.
  Assumes a 25 MHz system clock and word-addressed Avalon-MM access.
*/
`default_nettype none
package sqp_pkg;
  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RRQ_LEN    = 8'h95;  // eight length registers 0x95..0x9c
  localparam logic [7:0] IDX_MDQ_LEN    = 8'h94;
  localparam logic [7:0] IDX_MDQ_PTR    = 8'h9e;
  localparam logic [7:0] IDX_RRQ_AUTO   = 8'h9f;  // 0x9f..0xa6
  localparam logic [7:0] IDX_RRQ_PEEK   = 8'ha7;  // 0xa7..0xae
  localparam logic [7:0] IDX_GLOBAL_CONFIGURATION       = 8'haf;
  localparam logic [7:0] IDX_RRQ_SET_RD = 8'hb0;  // host read-pointer write, 0xb0..0xb7
  localparam int         NUM_RRQ        = 8;
  localparam int         NUM_STREAM     = 4;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          LEN_W          = 4;
  localparam logic [3:0]  LEN_MAX        = 4'hf;
  localparam int          PTR_W          = 16;
  localparam int          GLOBAL_CONFIGURATION_W         = 11;
  localparam logic [10:0] GLOBAL_CONFIGURATION_RESET     = 11'h000;
  localparam logic [3:0]  LEN_RESET      = 4'h0;
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam int          B_SEG          = 0;
  localparam int          B_RAS          = 1;
  localparam int          B_CELLPORT     = 2;
  localparam int          B_INT          = 3;
  localparam int          B_HEC          = 4;
  localparam int          B_UNASSIGNED   = 5;
  localparam int          B_PHYOAM       = 6;
  localparam int          B_F5TRANS      = 7;
  localparam int          B_TSFINE       = 8;
  localparam int          B_LOOPBACK     = 9;
  localparam int          B_PARODD       = 10;

  // ----------------------------------------------------------------
  // timing: timestamp tick periods
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 25_000_000;
  localparam int TS_COARSE_US     = 100;
  localparam int TS_FINE_US       = 10;
  localparam int TS_COARSE_CYC    = (CLK_HZ / 1_000_000) * TS_COARSE_US;
  localparam int TS_FINE_CYC      = (CLK_HZ / 1_000_000) * TS_FINE_US;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] wr;
    logic [15:0] rd;
  } sqp_ptrs_t;

  typedef struct packed {
    logic        segmentation_on;
    logic        reassembly_on;
    logic        cell_port_on;
    logic        interrupt_on;
    logic        header_check_on;
    logic        unassigned_cell_accept;
    logic        phy_oam_cell_accept;
    logic        f5_cell_transparent_mode;
    logic        timestamp_fine_resolution;
    logic        loopback_on;
    logic        parity_odd_select;
  } sqp_global_configuration_t;

  // engine request to a queue: one-cycle pulses
  typedef struct packed {
    logic       mdq_take;      // a descriptor is needed
    logic       mdq_give;      // a descriptor is released
    logic       rrq_push;      // a ready-queue entry is written
    logic [2:0] rrq_sel;
    logic [1:0] push_kind;     // 0 complete PDU, 1 first cell, 2 buffer done, 3 f5 cell
  } sqp_evt_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK  = 3'b010,
    ST_DONE = 3'b100
  } sqp_bus_st_t;
endpackage
`default_nettype wire

// ### src/sqp_regs.sv
/*
  Register bank for the MID descriptor queue pointers, the eight receive
  ready queue pointers and the low configuration bits. Also decodes cell
  handling from the configuration and provides a timestamp tick.
  Assumes an Avalon-MM master on sys_clk and an engine that pulses
  queue events on the same clock; cell pins arrive synchronised elsewhere.
*/
`default_nettype none
// What this block does
// - any write to the MID queue length clears both MID queue pointers
// - on descriptor need with pointers unequal, fetch at read pointer, advance with wrap
// - released descriptor written at write pointer, write pointer advances with wrap
// - MID queue holds 2^(len+1)-1 entries, length field at most 15
// - each ready queue holds 2^(len+1)-1 entries, length at most 15
// - both ready views show write pointer high half, read pointer low half
// - completed PDU descriptor written at write pointer, pointer advances with wrap
// - streaming queue n reports PDUs, queue n+4 reports early events
// - auto-advancing view read returns pointers then advances read pointer if pointers unequal
// - configuration bit 0 enables segmentation, bit 1 reassembly
// - bit 2 enables the cell port, bit 3 allows interrupts
// - bit 4 turns header error checking on or off
// - bit 5 accepts unassigned cells at VPI 0 / VCI 0 if filtered
// - bit 6 accepts OAM F1-F3 and PHY cells at VPI 0 / VCI 0
// - bit 7 selects cell FIFO or transparent mode via ready queue 0
// - bit 8 selects 100 us or 10 us timestamp resolution
// - bit 9 loops segmented cells back and ignores cell port input; here unassigned and PHY/OAM cells still pass in loopback
// - bit 10 selects even or odd byte parity on local memory
module sqp_regs #(
  parameter int NQ = 8
) (
  input  wire  logic                  sys_clk,
  input  wire  logic                  arst_n,
  input  wire  logic [9:0]            avs_address,
  input  wire  logic                  avs_read,
  input  wire  logic                  avs_write,
  input  wire  logic [31:0]           avs_writedata,
  input  wire  logic [3:0]            avs_byteenable,
  output var   logic [31:0]           avs_readdata,
  output var   logic                  avs_waitrequest,
  output var   logic [1:0]            avs_response,
  input  wire  sqp_pkg::sqp_evt_t     evt,
  input  wire  logic [3:0]            stream_mode,
  input  wire  logic                  cell_unassigned,
  input  wire  logic                  cell_phy_oam,
  input  wire  logic                  cell_f5,
  input  wire  logic                  cell_addr_zero,
  input  wire  logic                  cell_filter_hit,
  output var   logic                  mdq_fetch,
  output var   logic [15:0]           mdq_fetch_addr,
  output var   logic                  mdq_store,
  output var   logic [15:0]           mdq_store_addr,
  output var   logic                  mdq_empty,
  output var   logic                  rrq_store,
  output var   logic [2:0]            rrq_store_sel,
  output var   logic [15:0]           rrq_store_addr,
  output var   logic                  rrq_full,
  output var   sqp_pkg::sqp_global_configuration_t    global_configuration,
  output var   logic                  cell_accept,
  output var   logic                  f5_to_queue0,
  output var   logic                  ts_tick
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [3:0]               mdq_len_reg;
  sqp_pkg::sqp_ptrs_t       mdq_ptr_reg;
  logic [3:0]               rrq_len_reg [NQ];
  sqp_pkg::sqp_ptrs_t       rrq_ptr_reg [NQ];
  logic [10:0]              global_configuration_reg;
  sqp_pkg::sqp_bus_st_t     bus_st_reg;
  logic [31:0]              rd_next;
  logic [1:0]               resp_next;
  logic                     auto_hit;
  logic [2:0]               auto_q;
  logic [7:0]               idx;
  logic [15:0]              ts_cnt_reg;

  // wrap helper: next pointer modulo 2^(len+1)
  function automatic logic [15:0] ptr_inc(input logic [15:0] p, input logic [3:0] len);
    logic [16:0] span;
    span = 17'h1_0000 >> (4'hf - len);
    ptr_inc = ((17'(p) + 17'h0_0001) == span) ? 16'h0000 : 16'(p + 16'h0001);
  endfunction

  // queue full when advancing write would meet read
  function automatic logic q_full(input sqp_pkg::sqp_ptrs_t q, input logic [3:0] len);
    q_full = (ptr_inc(q.wr, len) == q.rd);
  endfunction

  assign idx = avs_address[7:0];

  // ----------------------------------------------------------------
  // bus handshake: request held, answered one cycle later
  // ----------------------------------------------------------------
  // a request is taken in ST_IDLE; waitrequest drops in ST_ACK where the master
  // samples; ST_DONE gives the master one edge to release before the next one
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      bus_st_reg <= sqp_pkg::ST_IDLE;
    else
    begin
      case (bus_st_reg)
        sqp_pkg::ST_IDLE: if (avs_read || avs_write) bus_st_reg <= sqp_pkg::ST_ACK;
        sqp_pkg::ST_ACK:  bus_st_reg <= sqp_pkg::ST_DONE;
        sqp_pkg::ST_DONE: bus_st_reg <= sqp_pkg::ST_IDLE;
        default:          bus_st_reg <= sqp_pkg::ST_IDLE;
      endcase
    end
  end

  // waitrequest high except in the answer cycle
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((bus_st_reg == sqp_pkg::ST_IDLE) && (avs_read || avs_write));
  end

  // read mux; unmapped reads return zero with a decode-error response
  always_comb
  begin
    rd_next   = 32'h0000_0000;
    resp_next = 2'b00;
    auto_hit  = 1'b0;
    auto_q    = 3'h0;
    if (avs_address[9:8] != 2'b00)
      resp_next = 2'b11;
    else if (idx == sqp_pkg::IDX_MDQ_LEN)
      rd_next = {28'h0, mdq_len_reg};
    else if (idx >= sqp_pkg::IDX_RRQ_LEN && idx < sqp_pkg::IDX_RRQ_LEN + 8'h08)
      rd_next = {28'h0, rrq_len_reg[3'(idx - sqp_pkg::IDX_RRQ_LEN)]};
    else if (idx == sqp_pkg::IDX_MDQ_PTR)
      rd_next = {mdq_ptr_reg.rd, mdq_ptr_reg.wr};
    else if (idx >= sqp_pkg::IDX_RRQ_AUTO && idx < sqp_pkg::IDX_RRQ_AUTO + 8'h08)
    begin
      auto_q   = 3'(idx - sqp_pkg::IDX_RRQ_AUTO);
      auto_hit = 1'b1;
      rd_next  = rrq_ptr_reg[auto_q];
    end
    else if (idx >= sqp_pkg::IDX_RRQ_PEEK && idx < sqp_pkg::IDX_RRQ_PEEK + 8'h08)
      rd_next = rrq_ptr_reg[3'(idx - sqp_pkg::IDX_RRQ_PEEK)];
    else if (idx == sqp_pkg::IDX_GLOBAL_CONFIGURATION)
      rd_next = {21'h0, global_configuration_reg};
    else if (idx >= sqp_pkg::IDX_RRQ_SET_RD && idx < sqp_pkg::IDX_RRQ_SET_RD + 8'h08)
      rd_next = {16'h0, rrq_ptr_reg[3'(idx - sqp_pkg::IDX_RRQ_SET_RD)].rd};
    else
      resp_next = 2'b11;
  end

  // read data and response registered with the answer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end
    else if (bus_st_reg == sqp_pkg::ST_IDLE && (avs_read || avs_write))
    begin
      avs_readdata <= avs_read ? rd_next : 32'h0000_0000;
      avs_response <= resp_next;
    end
  end

  logic take_wr;
  logic take_rd;
  assign take_wr = (bus_st_reg == sqp_pkg::ST_IDLE) && avs_write && (avs_address[9:8] == 2'b00);
  assign take_rd = (bus_st_reg == sqp_pkg::ST_IDLE) && avs_read && (avs_address[9:8] == 2'b00);

  // ----------------------------------------------------------------
  // configuration and lengths
  // ----------------------------------------------------------------
  // lengths are four bits so the 15 ceiling holds by width
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      global_configuration_reg    <= sqp_pkg::GLOBAL_CONFIGURATION_RESET;
      mdq_len_reg <= sqp_pkg::LEN_RESET;
      for (int i = 0; i < NQ; i++)
        rrq_len_reg[i] <= sqp_pkg::LEN_RESET;
    end
    else if (take_wr)
    begin
      if (idx == sqp_pkg::IDX_GLOBAL_CONFIGURATION)
      begin
        if (avs_byteenable[0]) global_configuration_reg[7:0]  <= avs_writedata[7:0];
        if (avs_byteenable[1]) global_configuration_reg[10:8] <= avs_writedata[10:8];
      end
      else if (idx == sqp_pkg::IDX_MDQ_LEN && avs_byteenable[0])
        mdq_len_reg <= avs_writedata[3:0];
      else if (idx >= sqp_pkg::IDX_RRQ_LEN && idx < sqp_pkg::IDX_RRQ_LEN + 8'h08 && avs_byteenable[0])
        rrq_len_reg[3'(idx - sqp_pkg::IDX_RRQ_LEN)] <= avs_writedata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // MID descriptor queue pointers
  // ----------------------------------------------------------------
  // a length write wins over everything, then host pointer writes, then engine
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      mdq_ptr_reg <= '{wr: sqp_pkg::PTR_RESET, rd: sqp_pkg::PTR_RESET};
    else if (take_wr && idx == sqp_pkg::IDX_MDQ_LEN)
      mdq_ptr_reg <= '{wr: sqp_pkg::PTR_RESET, rd: sqp_pkg::PTR_RESET};
    else if (take_wr && idx == sqp_pkg::IDX_MDQ_PTR)
    begin
      // initialisation by host before operation
      if (avs_byteenable[1:0] == 2'b11) mdq_ptr_reg.wr <= avs_writedata[15:0];
      if (avs_byteenable[3:2] == 2'b11) mdq_ptr_reg.rd <= avs_writedata[31:16];
    end
    else
    begin
      if (evt.mdq_take && mdq_ptr_reg.rd != mdq_ptr_reg.wr)
        mdq_ptr_reg.rd <= ptr_inc(mdq_ptr_reg.rd, mdq_len_reg);
      if (evt.mdq_give && !q_full(mdq_ptr_reg, mdq_len_reg))
        mdq_ptr_reg.wr <= ptr_inc(mdq_ptr_reg.wr, mdq_len_reg);
    end
  end

  // fetch and store strobes carry the pre-advance pointer as queue address
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mdq_fetch      <= 1'b0;
      mdq_fetch_addr <= 16'h0000;
      mdq_store      <= 1'b0;
      mdq_store_addr <= 16'h0000;
      mdq_empty      <= 1'b1;
    end
    else
    begin
      mdq_fetch      <= evt.mdq_take && (mdq_ptr_reg.rd != mdq_ptr_reg.wr);
      mdq_fetch_addr <= mdq_ptr_reg.rd;
      mdq_store      <= evt.mdq_give && !q_full(mdq_ptr_reg, mdq_len_reg);
      mdq_store_addr <= mdq_ptr_reg.wr;
      mdq_empty      <= (mdq_ptr_reg.rd == mdq_ptr_reg.wr);
    end
  end

  // ----------------------------------------------------------------
  // receive ready queues
  // ----------------------------------------------------------------
  // early events of a streaming queue land on its partner queue n+4
  logic [2:0] push_q;
  always_comb
  begin
    push_q = evt.rrq_sel;
    if (evt.push_kind == 2'd3)
      push_q = 3'h0;
    else if (evt.push_kind != 2'd0 && evt.rrq_sel < 3'h4 && stream_mode[evt.rrq_sel[1:0]])
      push_q = evt.rrq_sel + 3'h4;
  end

  logic push_ok;
  assign push_ok = evt.rrq_push && !q_full(rrq_ptr_reg[push_q], rrq_len_reg[push_q])
                   && (evt.push_kind != 2'd3 || global_configuration_reg[sqp_pkg::B_F5TRANS]);

  // one engine push and one host advance may hit the same queue together
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NQ; i++)
        rrq_ptr_reg[i] <= '{wr: sqp_pkg::PTR_RESET, rd: sqp_pkg::PTR_RESET};
    end
    else
    begin
      for (int i = 0; i < NQ; i++)
      begin
        if (take_wr && idx == sqp_pkg::IDX_RRQ_LEN + 8'(i))
          rrq_ptr_reg[i] <= '{wr: sqp_pkg::PTR_RESET, rd: sqp_pkg::PTR_RESET};
        else
        begin
          if (push_ok && push_q == 3'(i))
            rrq_ptr_reg[i].wr <= ptr_inc(rrq_ptr_reg[i].wr, rrq_len_reg[i]);
          if (take_rd && auto_hit && auto_q == 3'(i) && rrq_ptr_reg[i].rd != rrq_ptr_reg[i].wr)
            rrq_ptr_reg[i].rd <= ptr_inc(rrq_ptr_reg[i].rd, rrq_len_reg[i]);
          else if (take_wr && idx == sqp_pkg::IDX_RRQ_SET_RD + 8'(i) && avs_byteenable[1:0] == 2'b11)
            rrq_ptr_reg[i].rd <= avs_writedata[15:0];
        end
      end
    end
  end

  // store strobe for the ready-queue entry at the pre-advance write pointer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rrq_store      <= 1'b0;
      rrq_store_sel  <= 3'h0;
      rrq_store_addr <= 16'h0000;
      rrq_full       <= 1'b0;
    end
    else
    begin
      rrq_store      <= push_ok;
      rrq_store_sel  <= push_q;
      rrq_store_addr <= rrq_ptr_reg[push_q].wr;
      rrq_full       <= evt.rrq_push && !push_ok;
    end
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  // registered so every output comes from a flip-flop
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      global_configuration         <= '0;
      cell_accept  <= 1'b0;
      f5_to_queue0 <= 1'b0;
    end
    else
    begin
      global_configuration.segmentation_on           <= global_configuration_reg[sqp_pkg::B_SEG];
      global_configuration.reassembly_on             <= global_configuration_reg[sqp_pkg::B_RAS];
      global_configuration.cell_port_on              <= global_configuration_reg[sqp_pkg::B_CELLPORT];
      global_configuration.interrupt_on              <= global_configuration_reg[sqp_pkg::B_INT];
      global_configuration.header_check_on           <= global_configuration_reg[sqp_pkg::B_HEC];
      global_configuration.unassigned_cell_accept    <= global_configuration_reg[sqp_pkg::B_UNASSIGNED];
      global_configuration.phy_oam_cell_accept       <= global_configuration_reg[sqp_pkg::B_PHYOAM];
      global_configuration.f5_cell_transparent_mode  <= global_configuration_reg[sqp_pkg::B_F5TRANS];
      global_configuration.timestamp_fine_resolution <= global_configuration_reg[sqp_pkg::B_TSFINE];
      global_configuration.loopback_on               <= global_configuration_reg[sqp_pkg::B_LOOPBACK];
      global_configuration.parity_odd_select         <= global_configuration_reg[sqp_pkg::B_PARODD];
      // special cells only pass at VPI 0 / VCI 0 with the filter enabled
      if (cell_unassigned)
        cell_accept <= global_configuration_reg[sqp_pkg::B_UNASSIGNED] && cell_addr_zero && cell_filter_hit;
      else if (cell_phy_oam)
        cell_accept <= global_configuration_reg[sqp_pkg::B_PHYOAM] && cell_addr_zero && cell_filter_hit;
      else
        cell_accept <= cell_filter_hit && !global_configuration_reg[sqp_pkg::B_LOOPBACK];
      f5_to_queue0 <= cell_f5 && global_configuration_reg[sqp_pkg::B_F5TRANS];
    end
  end

  // ----------------------------------------------------------------
  // timestamp tick
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ts_cnt_reg <= 16'h0000;
      ts_tick    <= 1'b0;
    end
    else if (ts_cnt_reg >= 16'(global_configuration_reg[sqp_pkg::B_TSFINE] ? sqp_pkg::TS_FINE_CYC - 1
                                                          : sqp_pkg::TS_COARSE_CYC - 1))
    begin
      ts_cnt_reg <= 16'h0000;
      ts_tick    <= 1'b1;
    end
    else
    begin
      ts_cnt_reg <= ts_cnt_reg + 16'h0001;
      ts_tick    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### test/sqp_regs_asserts.sv
/* Port checks for sqp_regs: queue strobes, cell filter, tick spacing.
   Assumes a bind into sqp_regs and one clock domain. */
`default_nettype none
module sqp_regs_asserts (
  input wire logic               sys_clk,
  input wire logic               arst_n,
  input wire logic               avs_write,
  input wire sqp_pkg::sqp_evt_t  evt,
  input wire logic               mdq_empty,
  input wire logic               mdq_fetch,
  input wire logic               mdq_store,
  input wire logic               rrq_store,
  input wire logic [2:0]         rrq_store_sel,
  input wire logic               rrq_full,
  input wire sqp_pkg::sqp_global_configuration_t global_configuration,
  input wire logic               cell_unassigned,
  input wire logic               cell_phy_oam,
  input wire logic               cell_f5,
  input wire logic               cell_accept,
  input wire logic               f5_to_queue0,
  input wire logic               ts_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // tick spacing helper
  // ----------------------------------------------------------------
  int   ts_cnt;
  logic ts_ok;
  // a resolution change spoils the interval in flight, so skip it
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ts_cnt <= 0;
      ts_ok  <= 1'b0;
    end
    else
    begin
      ts_cnt <= ts_tick ? 0 : ts_cnt + 1;
      ts_ok  <= $changed(global_configuration.timestamp_fine_resolution) ? 1'b0 : (ts_tick | ts_ok);
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  fetch_when_ready_a: assert property (evt.mdq_take && !mdq_empty && !avs_write |=> mdq_fetch)
    else $error("descriptor fetch missing");
  no_fetch_empty_a: assert property (evt.mdq_take && mdq_empty && !avs_write |=> !mdq_fetch)
    else $error("fetch from empty queue");
  store_on_give_a: assert property (evt.mdq_give && !avs_write |=> mdq_store)
    else $error("descriptor release not stored");
  push_outcome_a: assert property (evt.rrq_push && !avs_write |=> rrq_store ^ rrq_full)
    else $error("push neither stored nor refused");
  push_queue_sel_a: assert property (rrq_store && $past(evt.push_kind) == 2'h0
    |-> rrq_store_sel == $past(evt.rrq_sel))
    else $error("complete frame stored in wrong queue");
  // the filter reads the register while global_configuration lags it by one cycle, so look at global_configuration one cycle on
  unassigned_drop_a: assert property (cell_unassigned ##1 !global_configuration.unassigned_cell_accept |-> !cell_accept)
    else $error("unassigned cell accepted");
  phy_oam_drop_a: assert property (cell_phy_oam && !cell_unassigned ##1 !global_configuration.phy_oam_cell_accept
    |-> !cell_accept)
    else $error("phy or oam cell accepted");
  f5_route_a: assert property (f5_to_queue0 |-> $past(cell_f5) && global_configuration.f5_cell_transparent_mode)
    else $error("f5 cell routed outside transparent mode");
  loopback_drop_a: assert property (!cell_unassigned && !cell_phy_oam ##1 global_configuration.loopback_on
    |-> !cell_accept)
    else $error("cell port input accepted in loopback");
  tick_period_a: assert property (ts_tick && ts_ok && $stable(global_configuration.timestamp_fine_resolution)
    |-> ts_cnt == (global_configuration.timestamp_fine_resolution ? sqp_pkg::TS_FINE_CYC - 1 : sqp_pkg::TS_COARSE_CYC - 1))
    else $error("timestamp tick spacing wrong");
endmodule
`default_nettype wire

// ### test/sqp_eng_model.sv
/* Model of the queue engine side: one-cycle event pulses.
   Assumes callers wait for each pulse task to return. */
`default_nettype none
module sqp_eng_model (
  input  wire logic               sys_clk,
  output var  sqp_pkg::sqp_evt_t  evt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial evt = '0;
  // pulse lasts one cycle, then a quiet edge before any next one
  task automatic pulse(input sqp_pkg::sqp_evt_t e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
  endtask
endmodule
`default_nettype wire

// ### test/sqp_regs_tb.sv
/* Self-checking bench for sqp_regs: queues, views, configuration.
   Assumes sqp_eng_model and the bound port checker. */
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module sqp_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [9:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'hf, stream_mode = 4'h0;
  logic [1:0]  avs_response, rsp;
  logic cell_unassigned = 0, cell_phy_oam = 0, cell_f5 = 0, cell_addr_zero = 0, cell_filter_hit = 0;
  logic avs_waitrequest, mdq_fetch, mdq_store, mdq_empty, rrq_store, rrq_full, cell_accept, f5_to_queue0, ts_tick;
  logic [15:0] mdq_fetch_addr, mdq_store_addr, rrq_store_addr, rnd = 16'h000a, crnd = 16'h000a;
  logic [2:0]  rrq_store_sel, qn;
  logic [1:0]  pk = 2'h0;
  sqp_pkg::sqp_evt_t  evt;
  sqp_pkg::sqp_global_configuration_t global_configuration;
  int errors = 0, n_compared = 0;
  sqp_regs uut (.*);
  sqp_eng_model eng (.sys_clk(sys_clk), .evt(evt));
  always #20 sys_clk = ~sys_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // packed global_configuration holds bit 0 in its top place
  function automatic logic [10:0] rev11(input logic [10:0] v);
    for (int i = 0; i < 11; i++) rev11[10-i] = v[i];
  endfunction
  // random cell flags every cycle keep the filter busy
  always @(posedge sys_clk)
  begin
    crnd <= lfsr(crnd);
    {cell_unassigned, cell_phy_oam, cell_f5, cell_addr_zero, cell_filter_hit} <= crnd[4:0];
  end
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // no cycle count assumed: only the hang guard ends a stuck wait
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {2'h0, a}, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, {2'h0, a}, 32'h0);
    `CHK(q, e)
  endtask
  // engine pulse, then sample the strobes it causes
  task automatic ev(input logic t, input logic g, input logic p, input logic [2:0] s);
    sqp_pkg::sqp_evt_t e;
    e = '0;
    e.mdq_take = t;
    e.mdq_give = g;
    e.rrq_push = p;
    e.rrq_sel = s;
    e.push_kind = pk;
    eng.pulse(e);
    @(posedge sys_clk);
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, well past the expected run of about 5900 cycles
  initial
  begin
    #(40 * 40000);
    errors++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_chk(sqp_pkg::IDX_MDQ_PTR, 32'h0);
    for (int i = 0; i < 8; i++) rd_chk(8'(sqp_pkg::IDX_RRQ_PEEK + i), 32'h0);
    wr(sqp_pkg::IDX_MDQ_LEN, 32'h1);
    wr(sqp_pkg::IDX_MDQ_PTR, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      ev(1'b1, 1'b0, 1'b0, 3'h0);
      `CHK(mdq_fetch, 1'(i < 3))
      if (i < 3) `CHK(mdq_fetch_addr, 16'(i))
    end
    ev(1'b0, 1'b1, 1'b0, 3'h0);
    `CHK(mdq_store_addr, 16'h0003)
    rd_chk(sqp_pkg::IDX_MDQ_PTR, 32'h0003_0000);
    wr(sqp_pkg::IDX_MDQ_LEN, 32'h1);
    rd_chk(sqp_pkg::IDX_MDQ_PTR, 32'h0);
    rnd = lfsr(rnd);
    qn = rnd[2:0];
    wr(8'(sqp_pkg::IDX_RRQ_LEN + qn), 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      ev(1'b0, 1'b0, 1'b1, qn);
      `CHK(rrq_full, 1'(i == 3))
      if (i < 3) `CHK(rrq_store_addr, 16'(i))
    end
    rd_chk(8'(sqp_pkg::IDX_RRQ_PEEK + qn), 32'h0003_0000);
    rd_chk(8'(sqp_pkg::IDX_RRQ_AUTO + qn), 32'h0003_0000);
    rd_chk(8'(sqp_pkg::IDX_RRQ_PEEK + qn), 32'h0003_0001);
    wr(8'(sqp_pkg::IDX_RRQ_SET_RD + qn), 32'h3);
    rd_chk(8'(sqp_pkg::IDX_RRQ_AUTO + qn), 32'h0003_0003);
    rd_chk(8'(sqp_pkg::IDX_RRQ_PEEK + qn), 32'h0003_0003);
    // streaming queue 1: early events go to queue 5, whole frames stay
    stream_mode <= 4'h2;
    pk = 2'h1;
    ev(1'b0, 1'b0, 1'b1, 3'h1);
    `CHK(rrq_store_sel, 3'h5)
    pk = 2'h0;
    ev(1'b0, 1'b0, 1'b1, 3'h1);
    `CHK(rrq_store_sel, 3'h1)
    // f5 cell while in cell fifo mode is refused
    pk = 2'h3;
    ev(1'b0, 1'b0, 1'b1, 3'h2);
    `CHK(rrq_full, 1'b1)
    pk = 2'h0;
    bus(1'b0, 10'h300, 32'h0);
    `CHK(rsp, 2'h3)
    for (int b = 0; b < 11; b++)
    begin
      wr(sqp_pkg::IDX_GLOBAL_CONFIGURATION, 32'h1 << b);
      @(posedge sys_clk);
      `CHK(global_configuration, rev11(11'h1 << b))
    end
    rnd = lfsr(rnd);
    wr(sqp_pkg::IDX_GLOBAL_CONFIGURATION, {21'h0, rnd[10:0] & 11'h6ff});
    rd_chk(sqp_pkg::IDX_GLOBAL_CONFIGURATION, {21'h0, rnd[10:0] & 11'h6ff});
    repeat (5100) @(posedge sys_clk);
    wr(sqp_pkg::IDX_GLOBAL_CONFIGURATION, 32'h1e0);
    repeat (600) @(posedge sys_clk);
    end_of_test();
  end
endmodule
bind sqp_regs sqp_regs_asserts chk (.*);
`default_nettype wire
